// ===== hw/tda_delay_top.sv
// Top of the tap delay control block: two master loops, two clock slices,
// two strobe buffers, one dynamic and one static data delay, and a
// register port with sticky interrupts.
// Assumes step, direction and reload come from fabric logic on clk.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tda_delay_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [tda_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tda_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tda_pkg::DATA_W-1:0] reg_rdata,
    // Master loop phase detector pins
    input wire logic [tda_pkg::N_DLL-1:0] dll_phase_lead,
    // Fabric nudge controls, one bit per unit
    input wire logic [tda_pkg::N_UNIT-1:0] tap_step,
    input wire logic [tda_pkg::N_UNIT-1:0] tap_dir,
    input wire logic [tda_pkg::N_UNIT-1:0] delay_reload_n,
    // Delay settings to the delay lines
    output logic [tda_pkg::N_EDGE-1:0][tda_pkg::CODE_W-1:0] slice_setting,
    output logic [tda_pkg::N_EDGE-1:0][tda_pkg::CODE_W-1:0] strobe_setting,
    output logic [tda_pkg::DYN_W-1:0] dyn_data_setting,
    output logic [tda_pkg::DYN_W-1:0] static_data_setting,
    // Status
    output logic [tda_pkg::N_UNIT-1:0] tap_limit_flag,
    output logic [tda_pkg::N_DLL-1:0] dll_locked,
    output logic irq
);
    localparam int CW = tda_pkg::CODE_W;
    localparam int DW = tda_pkg::DYN_W;
    localparam logic [CW-1:0] CODE_MAX = {CW{1'b1}};

    tda_pkg::tda_req_t req;
    logic [tda_pkg::CTRL_W-1:0] ctrl_q;
    logic [CW-1:0] fuse_q;
    logic [DW-1:0] dyn_default_q;
    logic [DW-1:0] static_q;
    logic [tda_pkg::N_EVT-1:0] irq_status_q;
    logic [tda_pkg::N_EVT-1:0] irq_mask_q;
    logic [tda_pkg::N_EVT-1:0] evt;
    logic [tda_pkg::N_DLL-1:0][CW-1:0] dll_code;
    logic [tda_pkg::N_DLL-1:0] dll_lock_now;
    logic [tda_pkg::N_DLL-1:0] dll_lock_d1_q;
    logic [tda_pkg::N_UNIT-1:0] limit_now;
    logic [tda_pkg::N_UNIT-1:0] limit_d1_q;
    tda_pkg::tda_tap_t [tda_pkg::N_EDGE-1:0] slice_tap;
    tda_pkg::tda_tap_t [tda_pkg::N_EDGE-1:0] strobe_tap;
    logic [tda_pkg::N_EDGE-1:0][CW-1:0] slice_base;
    logic [tda_pkg::N_EDGE-1:0][CW-1:0] strobe_base;
    logic [DW-1:0] dyn_now;
    logic dyn_limit;
    logic [tda_pkg::DATA_W-1:0] rdata_d;

    // Code picked by an edge from either corner loop
    function automatic logic [CW-1:0] pick(
        input logic [tda_pkg::N_DLL-1:0][CW-1:0] codes,
        input logic sel
    );
        pick = sel ? codes[1] : codes[0];
    endfunction

    // Master code plus signed fuse trim, clipped to the slice range
    function automatic logic [CW-1:0] trim(
        input logic [CW-1:0] code,
        input logic [CW-1:0] adj
    );
        logic signed [CW+1:0] sum;
        sum = $signed({2'b00, code}) + $signed({{2{adj[CW-1]}}, adj});
        if (sum < 0) begin
            trim = '0;
        end else if (sum > $signed({2'b00, CODE_MAX})) begin
            trim = CODE_MAX;
        end else begin
            trim = sum[CW-1:0];
        end
    endfunction

    function automatic logic wr_hit(
        input tda_pkg::tda_req_t r,
        input logic [tda_pkg::ADDR_W-1:0] a
    );
        wr_hit = r.wr && (r.addr == a);
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Master loops, one per bottom corner
    for (genvar i = 0; i < tda_pkg::N_DLL; i++) begin : g_dll
        tda_master_dll u_master_delay_lock_loop (
            .clk(clk),
            .reset_n(reset_n),
            .enable(ctrl_q[tda_pkg::CTRL_DLL_EN + i]),
            .phase_lead(dll_phase_lead[i]),
            .code_q(dll_code[i]),
            .locked_q(dll_lock_now[i])
        );
    end

    // Clock slices and strobe buffers, one of each per edge
    for (genvar e = 0; e < tda_pkg::N_EDGE; e++) begin : g_edge
        assign slice_base[e] = trim(
            pick(dll_code, ctrl_q[tda_pkg::CTRL_SLICE_SEL + e]),
            fuse_q);
        assign strobe_base[e] = pick(dll_code,
            ctrl_q[tda_pkg::CTRL_STROBE_SEL + e]);

        tda_tap_ctrl #(.W(CW)) u_clock_delay_slice (
            .clk(clk),
            .reset_n(reset_n),
            .reload_n(delay_reload_n[tda_pkg::U_SLICE0 + e]),
            .base(slice_base[e]),
            .step(tap_step[tda_pkg::U_SLICE0 + e]),
            .dir(tap_dir[tda_pkg::U_SLICE0 + e]),
            .setting(slice_tap[e].setting),
            .at_limit(slice_tap[e].limit)
        );

        tda_tap_ctrl #(.W(CW)) u_strobe_delay_buffer (
            .clk(clk),
            .reset_n(reset_n),
            .reload_n(delay_reload_n[tda_pkg::U_STROBE0 + e]),
            .base(strobe_base[e]),
            .step(tap_step[tda_pkg::U_STROBE0 + e]),
            .dir(tap_dir[tda_pkg::U_STROBE0 + e]),
            .setting(strobe_tap[e].setting),
            .at_limit(strobe_tap[e].limit)
        );

        assign limit_now[tda_pkg::U_SLICE0 + e] = slice_tap[e].limit;
        assign limit_now[tda_pkg::U_STROBE0 + e] = strobe_tap[e].limit;
    end

    // Dynamic data delay: 128 positions from a software default
    tda_tap_ctrl #(.W(DW)) u_dynamic_data_delay (
        .clk(clk),
        .reset_n(reset_n),
        .reload_n(delay_reload_n[tda_pkg::U_DYN]),
        .base(dyn_default_q),
        .step(tap_step[tda_pkg::U_DYN]),
        .dir(tap_dir[tda_pkg::U_DYN]),
        .setting(dyn_now),
        .at_limit(dyn_limit)
    );
    assign limit_now[tda_pkg::U_DYN] = dyn_limit;

    // Outputs registered; reload reaches the lines one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slice_setting <= '0;
            strobe_setting <= '0;
            dyn_data_setting <= '0;
            static_data_setting <= '0;
            tap_limit_flag <= '0;
            dll_locked <= '0;
        end else begin
            for (int e = 0; e < tda_pkg::N_EDGE; e++) begin
                slice_setting[e] <= slice_tap[e].setting;
                strobe_setting[e] <= strobe_tap[e].setting;
            end
            dyn_data_setting <= dyn_now;
            static_data_setting <= static_q;
            tap_limit_flag <= limit_now;
            dll_locked <= dll_lock_now;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= tda_pkg::CTRL_RST;
            fuse_q <= tda_pkg::FUSE_RST;
            dyn_default_q <= tda_pkg::DYN_DEFAULT_RST;
            static_q <= tda_pkg::STATIC_RST;
            irq_mask_q <= '0;
        end else begin
            if (wr_hit(req, tda_pkg::REG_CTRL)) begin
                ctrl_q <= req.wdata[tda_pkg::CTRL_W-1:0];
            end
            if (wr_hit(req, tda_pkg::REG_FUSE)) begin
                fuse_q <= req.wdata[CW-1:0];
            end
            if (wr_hit(req, tda_pkg::REG_DYN_DEFAULT)) begin
                dyn_default_q <= req.wdata[DW-1:0];
            end
            if (wr_hit(req, tda_pkg::REG_STATIC)) begin
                static_q <= req.wdata[DW-1:0];
            end
            if (wr_hit(req, tda_pkg::REG_IRQ_MASK)) begin
                irq_mask_q <= req.wdata[tda_pkg::N_EVT-1:0];
            end
        end
    end

    // Events: a flag newly raised, a loop gaining or losing lock
    assign evt = {dll_lock_d1_q & ~dll_lock_now,
                  dll_lock_now & ~dll_lock_d1_q,
                  limit_now & ~limit_d1_q};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            limit_d1_q <= '0;
            dll_lock_d1_q <= '0;
        end else begin
            limit_d1_q <= limit_now;
            dll_lock_d1_q <= dll_lock_now;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_q <= '0;
        end else if (wr_hit(req, tda_pkg::REG_IRQ_STATUS)) begin
            irq_status_q <= (irq_status_q &
                ~req.wdata[tda_pkg::N_EVT-1:0]) | evt;
        end else begin
            irq_status_q <= irq_status_q | evt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_q | evt) & irq_mask_q);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        case (req.addr)
            tda_pkg::REG_CTRL: rdata_d[tda_pkg::CTRL_W-1:0] = ctrl_q;
            tda_pkg::REG_FUSE: rdata_d[CW-1:0] = fuse_q;
            tda_pkg::REG_DYN_DEFAULT: rdata_d[DW-1:0] = dyn_default_q;
            tda_pkg::REG_STATIC: rdata_d[DW-1:0] = static_q;
            tda_pkg::REG_DLL_CODES: begin
                rdata_d[2*CW-1:0] = {dll_code[1], dll_code[0]};
                rdata_d[2*CW +: tda_pkg::N_DLL] = dll_lock_now;
            end
            tda_pkg::REG_SLICE: begin
                rdata_d[2*CW-1:0] = {slice_tap[1].setting,
                                     slice_tap[0].setting};
            end
            tda_pkg::REG_STROBE: begin
                rdata_d[2*CW-1:0] = {strobe_tap[1].setting,
                                     strobe_tap[0].setting};
            end
            tda_pkg::REG_DATA: begin
                // Delay in femtoseconds spares software the multiply
                rdata_d[DW-1:0] = dyn_now;
                rdata_d[tda_pkg::DATA_W-1:CW] = 24'(
                    int'(dyn_now) * tda_pkg::TAP_STEP_FS);
                rdata_d[DW] = 1'b0;
            end
            tda_pkg::REG_IRQ_STATUS: rdata_d[tda_pkg::N_EVT-1:0] = irq_status_q;
            tda_pkg::REG_IRQ_MASK: rdata_d[tda_pkg::N_EVT-1:0] = irq_mask_q;
            default: rdata_d = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule // tda_delay_top

// ===== hw/tda_master_dll.sv
// Master delay lock loop: steps a quarter-period code from a phase pin.
// Assumes the phase pin comes from an analog detector, not this clock.
`timescale 1ns/1ps
module tda_master_dll (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control and phase detector pin
    input wire logic enable,
    input wire logic phase_lead,
    // Code and lock state
    output logic [tda_pkg::CODE_W-1:0] code_q,
    output logic locked_q
);
    logic [2:0] sync_q;
    logic lead_q;
    logic last_dir_q;
    logic [3:0] turns_q;
    logic [3:0] run_q;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= '0;
            lead_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], phase_lead};
            if (sync_q[1] == sync_q[2]) begin
                lead_q <= sync_q[2];
            end
        end
    end

    // Replica chain of four stages; lead means the chain is too short
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= tda_pkg::DLL_CODE_RST;
        end else if (enable) begin
            if (lead_q && code_q != '1) begin
                code_q <= code_q + 1'b1;
            end else if (!lead_q && code_q != '0) begin
                code_q <= code_q - 1'b1;
            end
        end
    end

    // Lock once the code dithers, lose it on a long one-way run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_dir_q <= 1'b0;
            turns_q <= '0;
            run_q <= '0;
            locked_q <= 1'b0;
        end else if (!enable) begin
            turns_q <= '0;
            run_q <= '0;
            locked_q <= 1'b0;
        end else begin
            last_dir_q <= lead_q;
            if (lead_q != last_dir_q) begin
                run_q <= '0;
                if (turns_q != tda_pkg::LOCK_TURNS) begin
                    turns_q <= turns_q + 1'b1;
                end else begin
                    locked_q <= 1'b1;
                end
            end else if (run_q != tda_pkg::SLIP_RUN) begin
                run_q <= run_q + 1'b1;
            end else begin
                turns_q <= '0;
                locked_q <= 1'b0;
            end
        end
    end
endmodule // tda_master_dll

// ===== hw/tda_tap_ctrl.sv
// Tap setting with step nudging, saturation and asynchronous reload.
// Assumes step, dir and reload_n come from logic on the same clock.
`timescale 1ns/1ps
module tda_tap_ctrl #(
    parameter int W = 8
) (
    // Clock and resets
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reload_n,
    // Base value and nudge controls
    input wire logic [W-1:0] base,
    input wire logic step,
    input wire logic dir,
    // Current setting
    output logic [W-1:0] setting,
    output logic at_limit
);
    localparam logic [W-1:0] MAXV = {W{1'b1}};

    logic signed [W+1:0] off_q;
    logic rst_all_n;

    function automatic logic [W-1:0] clip(input logic signed [W+1:0] v);
        if (v < 0) begin
            clip = '0;
        end else if (v > $signed({2'b00, MAXV})) begin
            clip = MAXV;
        end else begin
            clip = v[W-1:0];
        end
    endfunction

    // Reload clears only the offset, so no signal is loaded under reset
    assign rst_all_n = reset_n & reload_n;
    assign setting = clip($signed({2'b00, base}) + off_q);
    assign at_limit = (setting == '0) || (setting == MAXV);

    always_ff @(posedge clk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            off_q <= '0;
        end else if (step) begin
            // Low steps up, high steps down; never past a bound
            if (!dir && setting != MAXV) begin
                off_q <= off_q + 1'b1;
            end else if (dir && setting != '0) begin
                off_q <= off_q - 1'b1;
            end
        end
    end
endmodule // tda_tap_ctrl

// ===== pkg/tda_pkg.sv
// Shared constants and types for the tap delay adjust block.
// Assumes a single 10 MHz clock and a plain register port.
package tda_pkg;
    // Clock and tap timing
    localparam int CLK_PERIOD_NS = 100;
    localparam real TAP_STEP_PS = 12.5;
    localparam int TAP_STEP_FS = int'(TAP_STEP_PS * 1000.0);

    // Widths and counts
    localparam int CODE_W = 8;
    localparam int DYN_W = 7;
    localparam int N_DLL = 2;
    localparam int N_EDGE = 2;
    localparam int N_UNIT = 5;
    localparam int N_EVT = 9;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Unit order on the step, direction and reload ports
    localparam int U_SLICE0 = 0;
    localparam int U_STROBE0 = 2;
    localparam int U_DYN = 4;

    // Master loop lock tracking
    localparam logic [3:0] LOCK_TURNS = 4'h8;
    localparam logic [3:0] SLIP_RUN = 4'hc;

    // Register word indices
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_FUSE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DYN_DEFAULT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STATIC = 4'h3;
    localparam logic [ADDR_W-1:0] REG_DLL_CODES = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SLICE = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STROBE = 4'h6;
    localparam logic [ADDR_W-1:0] REG_DATA = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h9;

    // Control field positions
    localparam int CTRL_SLICE_SEL = 0;
    localparam int CTRL_STROBE_SEL = 2;
    localparam int CTRL_DLL_EN = 4;
    localparam int CTRL_W = 6;

    // Status and interrupt bit positions
    localparam int EVT_LIMIT = 0;
    localparam int EVT_LOCK = 5;
    localparam int EVT_UNLOCK = 7;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h3c;
    localparam logic [CODE_W-1:0] FUSE_RST = 8'h00;
    localparam logic [DYN_W-1:0] DYN_DEFAULT_RST = 7'h40;
    localparam logic [DYN_W-1:0] STATIC_RST = 7'h00;
    localparam logic [CODE_W-1:0] DLL_CODE_RST = 8'h40;

    typedef struct packed {
        logic [CODE_W-1:0] setting;
        logic limit;
    } tda_tap_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tda_req_t;
endpackage

// ===== tb/tda_delay_top_sva.sv
// Port checker for the tap delay block: stepping, saturation, reload.
// Assumes the master loop codes have run down to zero before any reload.
`timescale 1ns/1ps
module tda_delay_top_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tda_pkg::DATA_W-1:0] reg_rdata,
    // Nudge controls
    input wire logic [tda_pkg::N_UNIT-1:0] tap_step,
    input wire logic [tda_pkg::N_UNIT-1:0] tap_dir,
    input wire logic [tda_pkg::N_UNIT-1:0] delay_reload_n,
    // Settings and flags
    input wire logic [tda_pkg::N_EDGE-1:0][tda_pkg::CODE_W-1:0] slice_setting,
    input wire logic [tda_pkg::N_EDGE-1:0][tda_pkg::CODE_W-1:0] strobe_setting,
    input wire logic [tda_pkg::DYN_W-1:0] dyn_data_setting,
    input wire logic [tda_pkg::N_UNIT-1:0] tap_limit_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Port lags the taking edge by two samples
    AST_STEP_UP: assert property (
        tap_step[0] && !tap_dir[0] && delay_reload_n[0] && !reg_wr
        ##1 delay_reload_n[0] && !reg_wr |=> slice_setting[0] ==
        (($past(slice_setting[0]) == 8'hff) ? 8'hff :
        $past(slice_setting[0]) + 8'h01))
        else $error("slice 0 missed an upward tap");
    AST_STEP_DN: assert property (
        tap_step[0] && tap_dir[0] && delay_reload_n[0] && !reg_wr
        ##1 delay_reload_n[0] && !reg_wr |=> slice_setting[0] ==
        (($past(slice_setting[0]) == 8'h00) ? 8'h00 :
        $past(slice_setting[0]) - 8'h01))
        else $error("slice 0 missed a downward tap");
    AST_LIMIT_SLICE: assert property (
        $past(reset_n) |-> tap_limit_flag[1] ==
        (slice_setting[1] == 8'hff || slice_setting[1] == 8'h00))
        else $error("slice 1 limit flag disagrees with setting");
    AST_NO_WRAP: assert property (
        slice_setting[1] == 8'hff && tap_step[1] && !tap_dir[1] &&
        delay_reload_n[1] |-> ##1 (slice_setting[1] != 8'h00) [*2])
        else $error("slice 1 wrapped past the top");
    AST_DYN_LOW: assert property (
        dyn_data_setting == 7'h00 && tap_step[4] && tap_dir[4] &&
        delay_reload_n[4] ##1 delay_reload_n[4] |=>
        dyn_data_setting != 7'h7f)
        else $error("dynamic delay wrapped below zero");
    AST_DYN_TOP: assert property (
        dyn_data_setting == 7'h7f && tap_step[4] && !tap_dir[4] &&
        delay_reload_n[4] && !reg_wr ##1 delay_reload_n[4] &&
        !tap_step[4] && !reg_wr |=> dyn_data_setting == 7'h7f)
        else $error("dynamic delay left its top position");
    AST_LIMIT_DYN: assert property (
        $past(reset_n) |-> tap_limit_flag[4] ==
        (dyn_data_setting == 7'h7f || dyn_data_setting == 7'h00))
        else $error("dynamic limit flag disagrees with setting");
    AST_STROBE_RELOAD: assert property (
        !delay_reload_n[2] ##1 !delay_reload_n[2] |=>
        strobe_setting[0] == 8'h00)
        else $error("strobe reload did not restore the code");
    AST_RDATA_IDLE: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
endmodule // tda_delay_top_sva

bind tda_delay_top tda_delay_top_sva u_tda_delay_top_sva (
    .clk(clk),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .tap_step(tap_step),
    .tap_dir(tap_dir),
    .delay_reload_n(delay_reload_n),
    .slice_setting(slice_setting),
    .strobe_setting(strobe_setting),
    .dyn_data_setting(dyn_data_setting),
    .tap_limit_flag(tap_limit_flag)
);

// ===== tb/tda_delay_top_tb_top.sv
// Self-checking bench for the tap delay block.
// Assumes a pin that never settles runs both loop codes down to zero.
`timescale 1ns/1ps
module tda_delay_top_tb_top;
    logic clk, reset_n, reg_wr, reg_rd, irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [1:0] dll_phase_lead, dll_locked;
    logic [4:0] tap_step, tap_dir, delay_reload_n, tap_limit_flag;
    logic [1:0][7:0] slice_setting, strobe_setting;
    logic [6:0] dyn_data_setting, static_data_setting;
    logic go, dir, slow, reload, busy;
    logic [2:0] unit;
    logic [8:0] count;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    tda_delay_top u_tda_delay_top (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dll_phase_lead(dll_phase_lead), .tap_step(tap_step),
        .tap_dir(tap_dir), .delay_reload_n(delay_reload_n),
        .slice_setting(slice_setting), .strobe_setting(strobe_setting),
        .dyn_data_setting(dyn_data_setting),
        .static_data_setting(static_data_setting),
        .tap_limit_flag(tap_limit_flag), .dll_locked(dll_locked),
        .irq(irq));
    tda_fabric_model u_tda_fabric_model (.clk(clk), .reset_n(reset_n),
        .go(go), .unit(unit), .dir(dir), .slow(slow), .count(count),
        .reload(reload), .tap_step(tap_step), .tap_dir(tap_dir),
        .delay_reload_n(delay_reload_n), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Alternating pin keeps the synced detector from agreeing
    always @(posedge clk) dll_phase_lead <= ~dll_phase_lead;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic nudge(input int u, input logic d, input int n,
                         input logic s);
        int k;
        k = 0;
        @(posedge clk);
        go <= 1'b1;
        unit <= 3'(u);
        dir <= d;
        count <= 9'(n);
        slow <= s;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (busy === 1'b1 && k < 700);
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic reload_unit(input int u);
        @(posedge clk);
        unit <= 3'(u);
        reload <= 1'b1;
        repeat (3) @(posedge clk);
        reload <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        check(slice_setting, 16'h4040);
        check(strobe_setting, 16'h4040);
        check(dyn_data_setting, 7'h40);
        check(static_data_setting, 7'h00);
        check(tap_limit_flag, 5'h00);
        rd(tda_pkg::REG_CTRL, rv);
        check(rv, 32'h3c);
        rd(tda_pkg::REG_DATA, rv);
        check(rv, (32'(64 * tda_pkg::TAP_STEP_FS) << 8) | 32'h40);
        rd(4'hf, rv);
        check(rv, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_steps();
        nudge(0, 1'b0, 5, 1'b0);
        check(slice_setting[0], 8'h05);
        nudge(0, 1'b1, 3, 1'b1);
        check(slice_setting[0], 8'h02);
        nudge(2, 1'b0, 2, 1'b0);
        check(strobe_setting[0], 8'h02);
        reload_unit(2);
        check(strobe_setting[0], 8'h00);
        $display("test steps done");
    endtask

    task automatic t_top();
        wr(tda_pkg::REG_IRQ_STATUS, 32'h1ff);
        nudge(1, 1'b0, 9'h0ff, 1'b0);
        check({tap_limit_flag[1], slice_setting[1]}, 9'h1ff);
        nudge(1, 1'b0, 3, 1'b0);
        check(slice_setting[1], 8'hff);
        rd(tda_pkg::REG_IRQ_STATUS, rv);
        check(rv, 32'h2);
        check(irq, 1'b0);
        wr(tda_pkg::REG_IRQ_MASK, 32'h1ff);
        check(irq, 1'b1);
        wr(tda_pkg::REG_IRQ_STATUS, 32'h2);
        check(irq, 1'b0);
        wr(tda_pkg::REG_FUSE, 32'h05);
        reload_unit(1);
        check({tap_limit_flag[1], slice_setting[1]}, 9'h005);
        $display("test top done");
    endtask

    task automatic t_dyn();
        nudge(4, 1'b1, 8'h40, 1'b0);
        check({tap_limit_flag[4], dyn_data_setting}, 8'h80);
        nudge(4, 1'b1, 2, 1'b1);
        check(dyn_data_setting, 7'h00);
        nudge(4, 1'b0, 9'h081, 1'b0);
        check({tap_limit_flag[4], dyn_data_setting}, 8'hff);
        rd(tda_pkg::REG_DATA, rv);
        check(rv, (32'(127 * tda_pkg::TAP_STEP_FS) << 8) | 32'h7f);
        wr(tda_pkg::REG_DYN_DEFAULT, 32'h10);
        reload_unit(4);
        check(dyn_data_setting, 7'h10);
        wr(tda_pkg::REG_STATIC, 32'h33);
        check(static_data_setting, 7'h33);
        $display("test dynamic done");
    endtask

    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        dll_phase_lead = 2'h0;
        go = 1'b0;
        unit = 3'h0;
        dir = 1'b0;
        slow = 1'b0;
        count = 9'h000;
        reload = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        // Loop codes walk down one a cycle until they rest at zero
        repeat (70) @(posedge clk);
        #1;
        check({strobe_setting, slice_setting}, 32'h0);
        t_steps();
        t_top();
        t_dyn();
        close_out();
    end
endmodule // tda_delay_top_tb_top

// ===== tb/tda_fabric_model.sv
// Fabric-side model issuing tap step runs and reload pulses.
// Assumes the bench starts a run only while busy is low.
`timescale 1ns/1ps
module tda_fabric_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Commands from the bench
    input wire logic go,
    input wire logic [2:0] unit,
    input wire logic dir,
    input wire logic slow,
    input wire logic [8:0] count,
    input wire logic reload,
    // Nudge controls to the block
    output logic [tda_pkg::N_UNIT-1:0] tap_step,
    output logic [tda_pkg::N_UNIT-1:0] tap_dir,
    output logic [tda_pkg::N_UNIT-1:0] delay_reload_n,
    output logic busy
);
    logic [8:0] left_q;
    logic gap_q;

    // One cycle pulses, back to back unless slow
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= 9'h000;
            gap_q <= 1'b0;
            tap_step <= '0;
        end else begin
            tap_step <= '0;
            if (go) begin
                left_q <= count;
                gap_q <= 1'b0;
            end else if (left_q != 9'h000 && !gap_q) begin
                tap_step[unit] <= 1'b1;
                left_q <= left_q - 9'h001;
                gap_q <= slow;
            end else begin
                gap_q <= 1'b0;
            end
        end
    end

    // Direction set a cycle ahead and held through the whole run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tap_dir <= '0;
        end else if (go) begin
            tap_dir[unit] <= dir;
        end
    end

    assign delay_reload_n = ~(reload ? (5'h01 << unit) : 5'h00);
    assign busy = (left_q != 9'h000) || (tap_step != '0);
endmodule // tda_fabric_model
